// ---- src/clock_supervisor_map.vh ----
// Register map, field positions, reset values and counts for the clock supervisor
`ifndef CLOCK_SUPERVISOR_MAP_VH
`define CLOCK_SUPERVISOR_MAP_VH

`define ADDR_CLOCK_SELECT 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_PERIODIC_RATE 8'h0C
`define ADDR_WATCHDOG_CONTROL 8'h10
`define ADDR_WATCHDOG_SERVICE 8'h14

// Clock select register bits
`define SEL_WAIT_WATCHDOG 0
`define SEL_WAIT_PERIODIC 1
`define SEL_WAIT_CORE 2
`define SEL_WAIT_SYNTH 3
`define SEL_WAIT_REDUCED_OSC 4
`define SEL_WAIT_SYSTEM 6
`define SEL_SYNTH_CLOCK 7
`define CLOCK_SELECT_RESET 8'h00

// Control register bits
`define CTL_SYNTH_POWER 0
`define CTL_MONITOR_EN 1
`define CTL_SELF_CLOCK_EN 2
`define CTL_WDOG_PSTOP_EN 3
`define CTL_PER_PSTOP_EN 4
`define CTL_PER_IRQ_EN 5
`define CONTROL_RESET 8'h07

// Status register bits
`define STS_PERIODIC_FLAG 0
`define STS_SELF_CLOCK 1
`define STS_CHECK_PENDING 2
`define STS_WAIT_ACTIVE 3

// Watchdog control bits
`define WDOG_WINDOW_EN 7
`define WDOG_CONTROL_RESET 8'h00
`define PERIODIC_RATE_RESET 8'h00

`define WDOG_KEY_ARM 16'h0055
`define WDOG_KEY_SERVE 16'h00AA

`define CHECK_WINDOW_CYCLES 16'hC350
`define OSC_OK_EDGES 13'h1000
`define WDOG_BASE_SHIFT 5'h0D
`define PER_BASE_SHIFT 5'h09

`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ---- src/quality_checker.v ----
// Clock quality checker: counts reference edges inside fallback-timed windows
`timescale 1ns/1ps
`include "clock_supervisor_map.vh"
module quality_checker #(
	parameter [15:0] WINDOW = `CHECK_WINDOW_CYCLES
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Events
	input wire start,
	input wire ref_tick,
	input wire fallback_tick,
	// Result
	output reg pending_r,
	output reg osc_ok_r
);
	localparam [12:0] LAST_EDGE = `OSC_OK_EDGES - 13'h0001;
	reg [15:0] window_r;
	reg [12:0] edges_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pending_r <= 1'b0;
			osc_ok_r <= 1'b0;
			window_r <= 16'h0000;
			edges_r <= 13'h0000;
		end else begin
			osc_ok_r <= 1'b0;
			if (start) begin
				pending_r <= 1'b1;
				window_r <= 16'h0000;
				edges_r <= 13'h0000;
			end else if (pending_r) begin
				if (ref_tick && edges_r == LAST_EDGE) begin
					pending_r <= 1'b0;
					osc_ok_r <= 1'b1;
					window_r <= 16'h0000;
					edges_r <= 13'h0000;
				end else if (fallback_tick && window_r == WINDOW - 16'h0001) begin
					window_r <= 16'h0000;
					edges_r <= 13'h0000;
				end else begin
					if (fallback_tick)
						window_r <= window_r + 16'h0001;
					if (ref_tick)
						edges_r <= edges_r + 13'h0001;
				end
			end
		end
	end
endmodule // quality_checker

// ---- src/rate_timer.v ----
// Rate-selected timeout counter shared by the watchdog and the periodic timer
`timescale 1ns/1ps
module rate_timer (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control
	input wire tick,
	input wire restart,
	input wire [2:0] rate,
	input wire [4:0] base_shift,
	// Status
	output reg expire_r,
	output wire late_quarter
);
	reg [24:0] count_r;
	wire [24:0] period;

	// Zero rate keeps the counter cleared, so the timer is stopped
	assign period = 25'h0000001 << (rate + base_shift - 5'h01);
	assign late_quarter = count_r >= (period - (period >> 2));

	always @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= 25'h0000000;
			expire_r <= 1'b0;
		end else begin
			expire_r <= 1'b0;
			if (restart || rate == 3'h0) begin
				count_r <= 25'h0000000;
			end else if (tick) begin
				if (count_r == period - 25'h0000001) begin
					count_r <= 25'h0000000;
					expire_r <= 1'b1;
				end else begin
					count_r <= count_r + 25'h0000001;
				end
			end
		end
	end
endmodule // rate_timer

// ---- src/clock_supervisor.v ----
// Clock supervisor: quality check, self-clock mode, watchdog, periodic timer, wait entry
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "clock_supervisor_map.vh"
module clock_supervisor #(
	parameter [15:0] CHECK_WINDOW = `CHECK_WINDOW_CYCLES,
	parameter [4:0] WDOG_SHIFT = `WDOG_BASE_SHIFT,
	parameter [4:0] PER_SHIFT = `PER_BASE_SHIFT
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire awvalid,
	output wire awready,
	input wire [7:0] awaddr,
	input wire [2:0] awprot,
	// AXI4-Lite write data
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	// AXI4-Lite write response
	output reg bvalid_r,
	input wire bready,
	output reg [1:0] bresp_r,
	// AXI4-Lite read address
	input wire arvalid,
	output wire arready,
	input wire [7:0] araddr,
	input wire [2:0] arprot,
	// AXI4-Lite read data
	output reg rvalid_r,
	input wire rready,
	output reg [31:0] rdata_r,
	output reg [1:0] rresp_r,
	// Reset and clock events, one-cycle pulses
	input wire power_on_reset,
	input wire low_voltage_reset,
	input wire full_stop_exit,
	input wire clock_monitor_fail,
	// Oscillator ticks, one-cycle enables
	input wire ref_osc_tick,
	input wire fallback_tick,
	// Low-power requests
	input wire wait_instruction,
	input wire wake_event,
	input wire pseudo_stop,
	// Clock control outputs
	output reg [1:0] clock_source_r,
	output wire synth_running,
	output wire fallback_osc_on,
	output wire voltage_regulator_on,
	output wire core_clock_en,
	output wire system_clock_en,
	output wire reduced_osc_amplitude,
	// Reset and interrupt outputs
	output reg system_reset_r,
	output wire periodic_irq
);
	localparam [2:0] W_IDLE = 3'd0;
	localparam [2:0] W_SEL_REF = 3'd1;
	localparam [2:0] W_SYNTH = 3'd2;
	localparam [2:0] W_CORE = 3'd3;
	localparam [2:0] W_SYSTEM = 3'd4;
	localparam [2:0] W_ACTIVE = 3'd5;
	localparam [1:0] SRC_REF = 2'b00;
	localparam [1:0] SRC_SYNTH = 2'b01;
	localparam [1:0] SRC_FALLBACK = 2'b10;

	reg [7:0] clock_select_r;
	reg [7:0] control_r;
	reg [7:0] periodic_rate_r;
	reg [7:0] watchdog_control_r;
	reg periodic_flag_r;
	reg self_clock_mode_r;
	reg service_armed_r;
	reg [2:0] wait_state_r;
	reg [2:0] wait_state_nxt;
	reg synth_gated_r;
	reg core_gated_r;
	reg system_gated_r;
	reg aw_hold_r;
	reg w_hold_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg [31:0] read_word;
	reg read_hit;

	wire do_write;
	wire wr_byte0;
	wire check_start;
	wire check_pending;
	wire osc_ok;
	wire monitor_on;
	wire self_clock_on;
	wire wait_active;
	wire wdog_enabled;
	wire wdog_tick;
	wire per_tick;
	wire wdog_expire;
	wire wdog_late;
	wire per_expire;
	wire service_write;
	wire service_bad;
	wire service_restart;
	wire per_restart;
	wire monitor_event;

	// Address decode used for both channels
	function is_mapped;
		input [7:0] addr;
		begin
			is_mapped = (addr == `ADDR_CLOCK_SELECT) || (addr == `ADDR_CONTROL) ||
				(addr == `ADDR_STATUS) || (addr == `ADDR_PERIODIC_RATE) ||
				(addr == `ADDR_WATCHDOG_CONTROL) || (addr == `ADDR_WATCHDOG_SERVICE);
		end
	endfunction

	// Write channel: address and data taken in either order, answered together
	assign awready = !aw_hold_r && !bvalid_r;
	assign wready = !w_hold_r && !bvalid_r;
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_byte0 = do_write && wstrb_r[0];
	assign arready = !rvalid_r;

	assign monitor_on = control_r[`CTL_MONITOR_EN];
	assign monitor_event = clock_monitor_fail && monitor_on;
	assign check_start = power_on_reset || low_voltage_reset || full_stop_exit ||
		monitor_event;
	assign wait_active = wait_state_r == W_ACTIVE;

	quality_checker #(
		.WINDOW(CHECK_WINDOW)
	) u_checker (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(check_start),
		.ref_tick(ref_osc_tick),
		.fallback_tick(fallback_tick),
		.pending_r(check_pending),
		.osc_ok_r(osc_ok)
	);

	// Self-clock mode needs both enables
	assign self_clock_on = monitor_on && control_r[`CTL_SELF_CLOCK_EN];

	// Gated reference clock for the watchdog and the periodic timer
	assign wdog_enabled = watchdog_control_r[2:0] != 3'h0;
	assign wdog_tick = ref_osc_tick &&
		!(pseudo_stop && !control_r[`CTL_WDOG_PSTOP_EN]) &&
		!(wait_active && clock_select_r[`SEL_WAIT_WATCHDOG]);
	assign per_tick = ref_osc_tick &&
		!(pseudo_stop && !control_r[`CTL_PER_PSTOP_EN]) &&
		!(wait_active && clock_select_r[`SEL_WAIT_PERIODIC]);

	// Service sequence decode
	assign service_write = wr_byte0 && awaddr_r == `ADDR_WATCHDOG_SERVICE && wdog_enabled;
	assign service_bad = service_write &&
		((wdata_r[15:0] != `WDOG_KEY_ARM && wdata_r[15:0] != `WDOG_KEY_SERVE) ||
		(watchdog_control_r[`WDOG_WINDOW_EN] && !wdog_late));
	assign service_restart = service_write && !service_bad && service_armed_r &&
		wdata_r[15:0] == `WDOG_KEY_SERVE;
	assign per_restart = wr_byte0 && awaddr_r == `ADDR_PERIODIC_RATE;

	rate_timer u_watchdog (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(wdog_tick),
		.restart(service_restart),
		.rate(watchdog_control_r[2:0]),
		.base_shift(WDOG_SHIFT),
		.expire_r(wdog_expire),
		.late_quarter(wdog_late)
	);

	rate_timer u_periodic (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(per_tick),
		.restart(per_restart),
		.rate(periodic_rate_r[2:0]),
		.base_shift(PER_SHIFT),
		.expire_r(per_expire),
		.late_quarter()
	);

	// Keep the fallback oscillator and regulator alive during any check
	assign fallback_osc_on = check_pending || self_clock_mode_r ||
		(control_r[`CTL_SYNTH_POWER] && !synth_gated_r);
	assign voltage_regulator_on = check_pending || !pseudo_stop;
	assign synth_running = fallback_osc_on;
	assign core_clock_en = !core_gated_r;
	assign system_clock_en = !system_gated_r;
	assign reduced_osc_amplitude = wait_active && clock_select_r[`SEL_WAIT_REDUCED_OSC];
	assign periodic_irq = periodic_flag_r && control_r[`CTL_PER_IRQ_EN];

	// Wait entry walks the gating steps in a fixed order
	always @* begin
		wait_state_nxt = wait_state_r;
		case (wait_state_r)
			W_IDLE: begin
				if (wait_instruction)
					wait_state_nxt = W_SEL_REF;
			end
			W_SEL_REF: wait_state_nxt = W_SYNTH;
			W_SYNTH: wait_state_nxt = W_CORE;
			W_CORE: wait_state_nxt = W_SYSTEM;
			W_SYSTEM: wait_state_nxt = W_ACTIVE;
			W_ACTIVE: begin
				if (wake_event)
					wait_state_nxt = W_IDLE;
			end
			default: wait_state_nxt = W_IDLE;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			wait_state_r <= W_IDLE;
			synth_gated_r <= 1'b0;
			core_gated_r <= 1'b0;
			system_gated_r <= 1'b0;
		end else begin
			wait_state_r <= wait_state_nxt;
			if (wait_state_r == W_ACTIVE && wake_event) begin
				synth_gated_r <= 1'b0;
				core_gated_r <= 1'b0;
				system_gated_r <= 1'b0;
			end else begin
				if (wait_state_r == W_SYNTH && clock_select_r[`SEL_WAIT_SYNTH])
					synth_gated_r <= 1'b1;
				if (wait_state_r == W_CORE &&
					(clock_select_r[`SEL_WAIT_CORE] || clock_select_r[`SEL_WAIT_SYSTEM]))
					core_gated_r <= 1'b1;
				if (wait_state_r == W_SYSTEM && clock_select_r[`SEL_WAIT_SYSTEM])
					system_gated_r <= 1'b1;
			end
		end
	end

	// Register file, hardware events win over software writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			clock_select_r <= `CLOCK_SELECT_RESET;
			control_r <= `CONTROL_RESET;
			periodic_rate_r <= `PERIODIC_RATE_RESET;
			watchdog_control_r <= `WDOG_CONTROL_RESET;
			periodic_flag_r <= 1'b0;
			self_clock_mode_r <= 1'b0;
			service_armed_r <= 1'b0;
			system_reset_r <= 1'b0;
			clock_source_r <= SRC_REF;
		end else begin
			system_reset_r <= 1'b0;
			if (wr_byte0) begin
				case (awaddr_r)
					`ADDR_CLOCK_SELECT: clock_select_r <= wdata_r[7:0];
					`ADDR_CONTROL: begin
						control_r <= wdata_r[7:0];
						// Powering down the synthesizer under its own clock would stall everything
						if (clock_select_r[`SEL_SYNTH_CLOCK])
							control_r[`CTL_SYNTH_POWER] <= 1'b1;
					end
					`ADDR_STATUS: begin
						if (wdata_r[`STS_PERIODIC_FLAG])
							periodic_flag_r <= 1'b0;
					end
					`ADDR_PERIODIC_RATE: periodic_rate_r <= {5'h00, wdata_r[2:0]};
					`ADDR_WATCHDOG_CONTROL: begin
						watchdog_control_r <= {wdata_r[7], 4'h0, wdata_r[2:0]};
					end
					default: begin
					end
				endcase
			end
			if (service_write) begin
				if (wdata_r[15:0] == `WDOG_KEY_ARM)
					service_armed_r <= 1'b1;
				else
					service_armed_r <= 1'b0;
			end
			if (!wdog_enabled)
				service_armed_r <= 1'b0;
			// Flag set beats a clear arriving in the same cycle
			if (per_expire)
				periodic_flag_r <= 1'b1;
			if (wait_state_r == W_SEL_REF && clock_select_r[`SEL_WAIT_SYNTH])
				clock_select_r[`SEL_SYNTH_CLOCK] <= 1'b0;
			if (service_bad || (wdog_expire && wdog_enabled))
				system_reset_r <= 1'b1;
			if (monitor_event) begin
				if (control_r[`CTL_SELF_CLOCK_EN]) begin
					self_clock_mode_r <= 1'b1;
					clock_select_r[`SEL_SYNTH_CLOCK] <= 1'b0;
				end else begin
					system_reset_r <= 1'b1;
					control_r[`CTL_SELF_CLOCK_EN] <= 1'b1;
				end
			end else if (osc_ok && self_clock_mode_r) begin
				// Checker has already stopped on its own: its pending flag drops with the osc_ok pulse
				self_clock_mode_r <= 1'b0;
			end
			if (self_clock_mode_r && self_clock_on)
				clock_source_r <= SRC_FALLBACK;
			else if (clock_select_r[`SEL_SYNTH_CLOCK])
				clock_source_r <= SRC_SYNTH;
			else
				clock_source_r <= SRC_REF;
		end
	end

	// Read mux
	always @* begin
		read_word = 32'h00000000;
		read_hit = is_mapped(araddr);
		case (araddr)
			`ADDR_CLOCK_SELECT: read_word = {24'h000000, clock_select_r};
			`ADDR_CONTROL: read_word = {24'h000000, control_r};
			`ADDR_STATUS: read_word = {28'h0000000, wait_active, check_pending,
				self_clock_mode_r, periodic_flag_r};
			`ADDR_PERIODIC_RATE: read_word = {24'h000000, periodic_rate_r};
			`ADDR_WATCHDOG_CONTROL: read_word = {24'h000000, watchdog_control_r};
			default: read_word = 32'h00000000;
		endcase
	end

	// Bus handshakes
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= is_mapped(awaddr_r) ? `RESP_OKAY : `RESP_DECERR;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
			if (arvalid && arready) begin
				rvalid_r <= 1'b1;
				rdata_r <= read_word;
				rresp_r <= read_hit ? `RESP_OKAY : `RESP_DECERR;
			end else if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
endmodule // clock_supervisor

// ---- test/supervisor_monitor.sv ----
// Port checker for the clock supervisor
`timescale 1ns/1ps
`include "clock_supervisor_map.vh"
module supervisor_monitor (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus
	input wire awvalid,
	input wire awready,
	input wire [7:0] awaddr,
	input wire wvalid,
	input wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire arvalid,
	input wire arready,
	input wire rvalid_r,
	// Events
	input wire power_on_reset,
	input wire low_voltage_reset,
	input wire full_stop_exit,
	input wire clock_monitor_fail,
	input wire pseudo_stop,
	// Clock and reset outputs
	input wire [1:0] clock_source_r,
	input wire voltage_regulator_on,
	input wire fallback_osc_on,
	input wire core_clock_en,
	input wire system_clock_en,
	input wire system_reset_r,
	input wire periodic_irq
);
	// Shadows of written words; forced bits are not tracked
	reg [7:0] ctl_r;
	reg [7:0] wdc_r;
	wire wr_go = awvalid && awready && wvalid && wready && wstrb[0];
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctl_r <= `CONTROL_RESET;
			wdc_r <= `WDOG_CONTROL_RESET;
		end else if (wr_go) begin
			if (awaddr == `ADDR_CONTROL) ctl_r <= wdata[7:0];
			if (awaddr == `ADDR_WATCHDOG_CONTROL) wdc_r <= wdata[7:0];
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_regulator_awake: assert property (!pseudo_stop |-> voltage_regulator_on)
		else $error("regulator off");
	a_check_start: assert property ($past(power_on_reset || low_voltage_reset || full_stop_exit)
		|-> voltage_regulator_on && fallback_osc_on) else $error("check not started");
	a_gate_order: assert property (!system_clock_en |-> !core_clock_en)
		else $error("core runs without system");
	a_fail_self: assert property (clock_monitor_fail && ctl_r[1] && ctl_r[2]
		|-> ##[1:3] clock_source_r == 2'b10) else $error("no self-clock");
	a_fail_reset: assert property (clock_monitor_fail && ctl_r[1] && !ctl_r[2]
		|-> ##[1:3] system_reset_r) else $error("no monitor reset");
	a_bad_key: assert property (wr_go && awaddr == `ADDR_WATCHDOG_SERVICE && wdc_r[2:0] != 0
		&& wdata[15:0] != `WDOG_KEY_ARM && wdata[15:0] != `WDOG_KEY_SERVE
		|-> ##[1:3] system_reset_r) else $error("bad key ignored");
	a_irq_enable: assert property (periodic_irq |-> ctl_r[5] || $past(ctl_r[5]))
		else $error("irq while disabled");
	a_reset_pulse: assert property (system_reset_r |=> !system_reset_r)
		else $error("reset not a pulse");
	a_read_answer: assert property (arvalid && arready |=> rvalid_r)
		else $error("read not answered");
	c_self: cover property (clock_source_r == 2'b10);
	c_reset: cover property (system_reset_r);
	c_wait: cover property (!system_clock_en);
	c_irq: cover property (periodic_irq);
endmodule // supervisor_monitor
bind clock_supervisor supervisor_monitor i_mon (.aclk, .aresetn, .awvalid, .awready, .awaddr,
	.wvalid, .wready, .wdata, .wstrb, .arvalid, .arready, .rvalid_r, .power_on_reset,
	.low_voltage_reset, .full_stop_exit, .clock_monitor_fail, .pseudo_stop, .clock_source_r,
	.voltage_regulator_on, .fallback_osc_on, .core_clock_en, .system_clock_en,
	.system_reset_r, .periodic_irq);

// ---- test/testbench.sv ----
// Self-checking testbench for the clock supervisor
`timescale 1ns/1ps
`include "clock_supervisor_map.vh"
module testbench;
	localparam [4:0] WS = 5'h02;
	localparam [4:0] PS = 5'h02;
	localparam [7:0] SEL = `ADDR_CLOCK_SELECT;
	localparam [7:0] CTL = `ADDR_CONTROL;
	localparam [7:0] STS = `ADDR_STATUS;
	localparam [7:0] PRT = `ADDR_PERIODIC_RATE;
	localparam [7:0] WDC = `ADDR_WATCHDOG_CONTROL;
	localparam [7:0] SVC = `ADDR_WATCHDOG_SERVICE;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0, cfg;
	logic [2:0] awprot = 0, arprot = 0;
	logic [3:0] wstrb = 4'hF;
	logic [31:0] wdata = 0, d, v;
	logic [1:0] rr, br;
	logic power_on_reset = 0, low_voltage_reset = 0, full_stop_exit = 0, clock_monitor_fail = 0;
	logic ref_osc_tick = 1, fallback_tick = 0, wait_instruction = 0, wake_event = 0;
	logic pseudo_stop = 0;
	wire awready, wready, arready, bvalid_r, rvalid_r, system_reset_r, periodic_irq;
	wire [1:0] bresp_r, rresp_r, clock_source_r;
	wire [31:0] rdata_r;
	wire synth_running, fallback_osc_on, voltage_regulator_on, core_clock_en, system_clock_en;
	wire reduced_osc_amplitude;
	int n_errors = 0, comparisons = 0, n_rst = 0, base = 0, fb_div = 1000, fb_cnt = 0, t;
	// Short window so that repeated windows fit in the run
	clock_supervisor #(.CHECK_WINDOW(16'h0010), .WDOG_SHIFT(WS), .PER_SHIFT(PS)) i_dut (.*);
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		fb_cnt <= (fb_cnt >= fb_div - 1) ? 0 : fb_cnt + 1;
		fallback_tick <= (fb_cnt == 0);
		if (system_reset_r === 1'b1) n_rst <= n_rst + 1;
	end
	function int period(input int rate, input int shift);
		return 1 << (rate + shift - 1);
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task results;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task rst_is(input int e);
		chk(n_rst - base, e);
		base = n_rst;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] val);
		bit ad, dd;
		ad = 0;
		dd = 0;
		t = 0;
		awaddr <= a;
		wdata <= val;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && dd) && t < 50) begin
			@(posedge aclk);
			t++;
			if (!ad && awready) begin
				ad = 1;
				awvalid <= 0;
			end
			if (!dd && wready) begin
				dd = 1;
				wvalid <= 0;
			end
		end
		while (!bvalid_r && t < 50) begin
			@(posedge aclk);
			t++;
		end
		br = bresp_r;
		if (t >= 50) chk(0, 1);
	endtask
	task rd(input logic [7:0] a);
		t = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin @(posedge aclk); t++; end while (!arready && t < 50);
		arvalid <= 0;
		do begin @(posedge aclk); t++; end while (!rvalid_r && t < 50);
		d = rdata_r;
		rr = rresp_r;
		if (t >= 50) chk(0, 1);
	endtask
	task do_reset;
		aresetn <= 0;
		tick(20);
		aresetn <= 1;
		tick(1);
		base = n_rst;
	endtask
	task fail_pulse;
		clock_monitor_fail <= 1;
		tick(1);
		clock_monitor_fail <= 0;
		tick(3);
	endtask
	initial begin
		v = $urandom(20);
		do_reset;
		rd(SEL); chk(d, `CLOCK_SELECT_RESET);
		rd(CTL); chk(d, `CONTROL_RESET);
		rd(PRT); chk(d, `PERIODIC_RATE_RESET);
		rd(WDC); chk(d, `WDOG_CONTROL_RESET);
		rd(SVC); chk(d, 0);
		rd(8'h18); chk(rr, `RESP_DECERR);
		wr(8'h18, 0); chk(br, `RESP_DECERR);
		tick(600); rst_is(0);
		wr(WDC, 7);
		repeat (8) begin
			tick(period(7, WS) / 4);
			wr(SVC, `WDOG_KEY_ARM);
			wr(SVC, `WDOG_KEY_SERVE);
		end
		rst_is(0);
		tick(period(7, WS) + 20); rst_is(1);
		do_reset;
		wr(WDC, 7);
		v = $urandom;
		if (v[15:0] == `WDOG_KEY_ARM || v[15:0] == `WDOG_KEY_SERVE) v = 32'h1234;
		wr(SVC, v); tick(4); rst_is(1);
		do_reset;
		wr(WDC, 8'h87); wr(SVC, `WDOG_KEY_ARM); tick(4); rst_is(1);
		do_reset;
		wr(WDC, 8'h87);
		tick(period(7, WS) * 3 / 4 + 8);
		wr(SVC, `WDOG_KEY_ARM);
		wr(SVC, `WDOG_KEY_SERVE);
		tick(period(7, WS) / 2); rst_is(0);
		// Halted in pseudo-stop without its enable
		wr(WDC, 7);
		pseudo_stop <= 1;
		tick(600); rst_is(0);
		wr(CTL, 8'h0F); tick(300); rst_is(1);
		pseudo_stop <= 0;
		do_reset;
		wr(CTL, 8'h27); wr(PRT, 1); tick(period(1, PS) + 4);
		chk(periodic_irq, 1);
		rd(STS); chk(d[0], 1);
		wr(PRT, 7);
		wr(STS, 1);
		repeat (4) begin
			tick(period(7, PS) / 2);
			wr(PRT, 7);
		end
		rd(STS); chk(d[0], 0);
		wr(PRT, 0); wr(STS, 1); tick(600);
		rd(STS); chk(d[0], 0);
		do_reset;
		wr(PRT, 1);
		for (int i = 0; i < 5; i++) begin
			cfg = (i == 0) ? 8'hDF : ($urandom & 8'hDF);
			wr(SEL, cfg);
			wait_instruction <= 1;
			tick(1);
			wait_instruction <= 0;
			tick(7);
			chk(core_clock_en, !(cfg[2] || cfg[6]));
			chk(system_clock_en, !cfg[6]);
			chk(reduced_osc_amplitude, cfg[4]);
			chk(synth_running, !cfg[3]);
			rd(STS); chk(d[3], 1);
			wr(STS, 1); tick(8);
			rd(STS); chk(d[0], !cfg[1]);
			// Short watchdog period: only its wait stop bit keeps resets away
			wr(WDC, 1); tick(20); wr(WDC, 0); tick(2);
			chk(n_rst == base, cfg[0]);
			base = n_rst;
			rd(SEL); chk(d[7], cfg[7] && !cfg[3]);
			wake_event <= 1;
			tick(1);
			wake_event <= 0;
			tick(3);
			chk(core_clock_en && system_clock_en, 1);
		end
		wr(SEL, 8'h80); wr(CTL, 8'h06);
		rd(CTL); chk(d[0], 1);
		for (int e = 0; e < 3; e++) begin
			do_reset;
			pseudo_stop <= 1;
			tick(2); chk(voltage_regulator_on, 0);
			{full_stop_exit, low_voltage_reset, power_on_reset} <= 3'b001 << e;
			tick(1);
			{full_stop_exit, low_voltage_reset, power_on_reset} <= 3'b000;
			tick(2); chk(voltage_regulator_on && fallback_osc_on, 1);
		end
		pseudo_stop <= 0;
		do_reset;
		wr(CTL, 8'h03); fail_pulse; rst_is(1);
		rd(CTL); chk(d[2], 1);
		do_reset;
		// Windows too short for the edge count never succeed
		fb_div = 100;
		wr(SEL, 8'h80); fail_pulse;
		chk(clock_source_r, 2'b10);
		rd(SEL); chk(d[7], 0);
		tick(6000); rd(STS); chk(d[2:1], 2'b11);
		// Fresh check at slow fallback rate, so the edge count decides
		fb_div = 1000;
		fail_pulse;
		t = 0;
		while (clock_source_r !== 2'b00 && t < 20000) begin
			tick(1);
			t++;
		end
		chk(t, 4096);
		rd(STS); chk(d[2:1], 2'b00);
		results;
	end
	initial begin
		#600000;
		n_errors++;
		results;
	end
endmodule // testbench
